// ---- rtl/agc_defs.svh ----
/*
  Register indexes, field positions and reset values of the AGC.
  Assumes inclusion by bare name from the module.
*/
// How it works
// - Bass lift ignored while multiband gate off.
// - Split each channel into bass and master.
// - Master and bass detectors separate, bass floor tied to master.
// - Bass reduction before lift at least master minus coupling.
// - Zero coupling default gives no bass boost.
// - Window slows master band only.
// - Window full release side, half attack.
// - Outside window fast rates, inner quarter of window slow.
// - Rates blend in quarter steps across window edge.
// - Window size resets to three dB.
// - Ratio selectable down to two to one.
// - Bass threshold fades as coupling grows.
// - Gated gain drifts slowly to idle target.
// - Idle reduction is drive minus idle offset.
// - Separate bass and master time settings.
// - Allpass mode: first order, both 3 dB.
// - Linear mode: upper band is input minus lower.
// - Matrix selects left/right or sum/difference.
// - Channel reduction spread limited, zero equal.
// - Master delta offsets difference channel threshold.
// - Bass delta offsets difference bass threshold.
// - Silence gate asserts below gate threshold.
`ifndef AGC_DEFS_SVH
`define AGC_DEFS_SVH
`define A_CTRL 5'h00
`define A_DRIVE 5'h01
`define A_MTHR 5'h02
`define A_BTHR 5'h03
`define A_CPL 5'h04
`define A_WIN 5'h05
`define A_MATK 5'h06
`define A_MREL 5'h07
`define A_BATK 5'h08
`define A_BREL 5'h09
`define A_WREL 5'h0A
`define A_GTHR 5'h0B
`define A_IDLE 5'h0C
`define A_SPRD 5'h0D
`define A_MDLT 5'h0E
`define A_BDLT 5'h0F
`define A_MBG 5'h10
`define A_LIFT 5'h11
`define NCFG 18
`define S_MGR0 5'h18
`define S_MGR1 5'h19
`define S_BGR0 5'h1A
`define S_BGR1 5'h1B
`define S_FLAG 5'h1C
`define C_SD 0
`define C_LIN 1
`define C_RAT_LO 2
`define C_RAT_HI 3
`define C_GATE 4
`define C_MBG 5
`define RV_WIN 16'h0018
`define RV_MTHR 16'hFF80
`define RV_BTHR 16'hFF80
`define RV_GTHR 16'hFE20
`define RV_MBG 16'hFE20
`define RV_FAST 16'h0200
`define RV_SLOW 16'h0040
`define RV_WREL 16'h0008
`define RV_ZERO 16'h0000
`define DB6 12'h030
`define GR_ONE 12'h100
`endif

// ---- rtl/agc_pkg.sv ----
/*
  Types shared by the AGC design.
  Assumes the constant header is on the include path.
*/
package agc_pkg;
  // One stereo sample, left and right words.
  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } stereo_s;
  // Compression ratio choices.
  typedef enum logic [1:0] {
    RATIO_INF, RATIO_4, RATIO_3, RATIO_2
  } ratio_e;
  // Gain reduction state: 1/8 dB units with 12 fraction bits.
  typedef logic [23:0] gr_t;
endpackage

// ---- rtl/agc_two_band.sv ----
/*
  Stereo two-band gated AGC with window, coupling and matrix.
  Assumes SAMPLE_EN comes from logic on REF_CLK, one pulse per sample,
  and a register master on the same clock.
*/
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "agc_defs.svh"
module agc_two_band
  import agc_pkg::*;
#(
  parameter int XO_SHIFT = 5
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Register port.
  input wire logic [4:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // Sample stream.
  input wire logic SAMPLE_EN,
  input wire stereo_s IN_DATA,
  output stereo_s OUT_DATA,
  output logic OUT_VALID
);
  // The one-pole split needs a shift the accumulator can hold.
  if (XO_SHIFT < 1 || XO_SHIFT > 12) begin : g_chk
    $error("XO_SHIFT out of range");
  end

  // Saturate a 17-bit value into 16 bits.
  function automatic logic signed [15:0] sat16(
    input logic signed [16:0] v);
    if (v[16] != v[15]) begin
      return v[16] ? 16'sh8000 : 16'sh7FFF;
    end
    return v[15:0];
  endfunction

  // Rough level in 1/8 dB below full scale from the leading one.
  function automatic logic signed [11:0] lvl8(
    input logic signed [15:0] v);
    logic [15:0] m;
    logic [15:0] s;
    logic signed [11:0] r;
    m = v[15] ? 16'(-v) : 16'(v);
    r = 12'shD00;
    for (int i = 0; i < 16; i++) begin
      s = 16'(m << (15 - i));
      if (m[i]) begin
        r = 12'((i - 15) * 48 + int'(s[14:12]) * 6);
      end
    end
    return r;
  endfunction

  // Slope of reduction per dB over threshold, 8 fraction bits.
  function automatic logic [8:0] slope(input ratio_e r);
    case (r)
      RATIO_INF: return 9'h100;
      RATIO_4: return 9'h0C0;
      RATIO_3: return 9'h0AB;
      RATIO_2: return 9'h080;
      default: return 9'h100;
    endcase
  endfunction

  // Static reduction wanted for a level against a threshold.
  function automatic logic [11:0] target(
    input logic signed [11:0] lvl,
    input logic signed [15:0] drv,
    input logic signed [15:0] thr,
    input logic [8:0] k);
    logic signed [17:0] o;
    logic [25:0] p;
    o = 18'(lvl) + 18'(drv) - 18'(thr);
    if (o <= 0) begin
      return 12'h000;
    end
    p = o[16:0] * k;
    if (p[25:20] != 6'h00) begin
      return 12'hFFF;
    end
    return p[19:8];
  endfunction

  // Linear gain in Q15 for a reduction in 1/8 dB.
  function automatic logic [15:0] gq15(input logic [11:0] g);
    logic [11:0] sh;
    logic [11:0] fr;
    sh = g / `DB6;
    fr = g - 12'(sh * `DB6);
    if (sh > 12'h00F) begin
      return 16'h0000;
    end
    return 16'((32'h7FFF - 32'(fr) * 32'h155) >> sh);
  endfunction

  // Move a state toward its target by at most one rate step.
  function automatic gr_t approach(input gr_t cur, input gr_t tgt,
    input logic [15:0] rate);
    gr_t r;
    r = {8'h00, rate};
    if (tgt > cur) begin
      return (tgt - cur > r) ? cur + r : tgt;
    end
    return (cur - tgt > r) ? cur - r : tgt;
  endfunction

  // Hold a reduction within a spread of a reference reduction.
  function automatic logic [11:0] clampd(input logic [11:0] a,
    input logic [11:0] b, input logic [11:0] sp);
    logic signed [13:0] x;
    logic signed [13:0] l;
    logic signed [13:0] h;
    x = $signed({2'b00, a});
    l = $signed({2'b00, b}) - $signed({2'b00, sp});
    h = $signed({2'b00, b}) + $signed({2'b00, sp});
    if (x < l) begin
      return l[11:0];
    end
    if (x > h) begin
      return h[11:0];
    end
    return a;
  endfunction

  // Reset value of each setting register.
  function automatic logic [15:0] rst_val(input logic [4:0] i);
    case (i)
      `A_WIN: return `RV_WIN;
      `A_MTHR: return `RV_MTHR;
      `A_BTHR: return `RV_BTHR;
      `A_GTHR: return `RV_GTHR;
      `A_MBG: return `RV_MBG;
      `A_MATK, `A_BATK: return `RV_FAST;
      `A_MREL, `A_BREL: return `RV_SLOW;
      `A_WREL: return `RV_WREL;
      default: return `RV_ZERO;
    endcase
  endfunction

  // Setting registers, written by software.
  logic [15:0] cfg [0:`NCFG-1];
  // Per-channel sample, band and level signals.
  logic signed [15:0] xin [0:1];
  logic signed [15:0] lo [0:1];
  logic signed [15:0] hi [0:1];
  logic signed [15:0] yout [0:1];
  logic signed [11:0] lvl_x [0:1];
  // Gain reduction states and applied reductions.
  gr_t mgr [0:1];
  gr_t bgr [0:1];
  logic [11:0] mraw [0:1];
  logic [11:0] braw [0:1];
  logic [11:0] bsel [0:1];
  logic [11:0] mapp [0:1];
  logic [11:0] bapp [0:1];

  // Decoded controls.
  wire logic sd_mode = cfg[`A_CTRL][`C_SD];
  wire logic lin_split = cfg[`A_CTRL][`C_LIN];
  wire ratio_e ratio = ratio_e'(cfg[`A_CTRL][`C_RAT_HI:`C_RAT_LO]);
  wire logic gate_en = cfg[`A_CTRL][`C_GATE];
  wire logic mbg_en = cfg[`A_CTRL][`C_MBG];
  wire logic signed [15:0] drive = cfg[`A_DRIVE];
  wire logic signed [15:0] mthr = cfg[`A_MTHR];
  wire logic signed [15:0] bthr = cfg[`A_BTHR];
  wire logic [7:0] cpl = cfg[`A_CPL][7:0];
  wire logic [11:0] win = cfg[`A_WIN][11:0];
  wire logic [15:0] matk = cfg[`A_MATK];
  wire logic [15:0] mrel = cfg[`A_MREL];
  wire logic [15:0] batk = cfg[`A_BATK];
  wire logic [15:0] brel = cfg[`A_BREL];
  wire logic [15:0] wrel = cfg[`A_WREL];
  wire logic signed [15:0] gthr = cfg[`A_GTHR];
  wire logic signed [15:0] idle_off = cfg[`A_IDLE];
  wire logic [11:0] spread = cfg[`A_SPRD][11:0];
  wire logic signed [15:0] mdelta = cfg[`A_MDLT];
  wire logic signed [15:0] bdelta = cfg[`A_BDLT];
  wire logic signed [15:0] mbthr = cfg[`A_MBG];
  wire logic [7:0] lift = cfg[`A_LIFT][7:0];
  wire logic [8:0] k_slope = slope(ratio);

  wire logic gate = gate_en && lvl_x[0] < gthr && lvl_x[1] < gthr;
  // Multiband gate, which alone lets the bass lift act.
  wire logic mb_gate = lvl_x[0] < mbthr && lvl_x[1] < mbthr;
  wire logic lift_on = mbg_en && mb_gate;

  wire logic signed [16:0] idl = 17'(drive) - 17'(idle_off);
  wire logic [11:0] idle = idl[16] ? 12'h000 :
    (idl[15:12] != 4'h0) ? 12'hFFF : idl[11:0];

  wire logic signed [16:0] in_sum =
    17'(IN_DATA.left) + 17'(IN_DATA.right);
  wire logic signed [16:0] in_dif =
    17'(IN_DATA.left) - 17'(IN_DATA.right);
  assign xin[0] = sd_mode ? in_sum[16:1] : IN_DATA.left;
  assign xin[1] = sd_mode ? in_dif[16:1] : IN_DATA.right;

  wire logic [8:0] b_wt = 9'(`GR_ONE) - {1'b0, cpl};
  wire logic signed [25:0] bt_p = bthr * $signed({1'b0, b_wt});

  assign mapp[0] = mraw[0];
  assign mapp[1] = clampd(mraw[1], mraw[0], spread);
  assign bapp[0] = braw[0];
  assign bapp[1] = clampd(braw[1], braw[0], spread);

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    // One-pole lowpass state, 16 fraction bits.
    logic signed [31:0] lo_acc;
    wire logic signed [32:0] xo_d =
      $signed({xin[ch][15], xin[ch], 16'h0000}) -
      $signed({lo_acc[31], lo_acc});
    wire logic signed [32:0] xo_s = xo_d >>> XO_SHIFT;
    wire logic [31:0] next_lo = lo_acc + xo_s[31:0];
    assign lo[ch] = lo_acc[31:16];
    wire logic signed [16:0] hi_lin = 17'(xin[ch]) - 17'(lo[ch]);
    assign hi[ch] = sat16(lin_split ? hi_lin : -hi_lin);
    assign lvl_x[ch] = lvl8(xin[ch]);
    wire logic is_dif = sd_mode && ch == 1;
    wire logic signed [15:0] thr_m =
      mthr + (is_dif ? mdelta : 16'sh0000);
    wire logic signed [15:0] thr_b =
      bt_p[23:8] + (is_dif ? bdelta : 16'sh0000);
    wire logic [11:0] tgt_m = target(lvl8(hi[ch]), drive, thr_m,
      k_slope);
    wire logic [11:0] tgt_b = target(lvl8(lo[ch]), drive, thr_b,
      k_slope);
    wire gr_t mt = {gate ? idle : tgt_m, 12'h000};
    wire gr_t bt = {gate ? idle : tgt_b, 12'h000};
    wire logic atk = mt > mgr[ch];
    wire gr_t mag = atk ? mt - mgr[ch] : mgr[ch] - mt;
    wire gr_t edg = atk ? {1'b0, win, 11'h000} : {win, 12'h000};
    wire logic [25:0] mag4 = {mag, 2'b00};
    wire logic [25:0] e2 = {1'b0, edg, 1'b0};
    wire logic [25:0] e3 = 26'(edg) + e2;
    wire logic [1:0] q = 2'(mag4 >= 26'(edg)) + 2'(mag4 >= e2) +
      2'(mag4 >= e3);
    wire logic [15:0] fast = atk ? matk : mrel;
    wire logic signed [17:0] span = 18'(fast) - 18'(wrel);
    wire logic signed [20:0] sq = span * $signed({1'b0, q});
    wire logic [17:0] bl18 = 18'(wrel) + 18'(sq >>> 2);
    wire logic [15:0] mrate = gate ? wrel :
      (mag >= edg) ? fast : bl18[15:0];
    wire logic [15:0] brate = gate ? wrel :
      (bt > bgr[ch]) ? batk : brel;
    assign mraw[ch] = mgr[ch][23:12];
    wire logic signed [13:0] bc =
      $signed({2'b00, mraw[ch]}) - $signed({6'h00, cpl});
    wire logic [11:0] bint = bgr[ch][23:12];
    assign bsel[ch] = (bc > $signed({2'b00, bint})) ? bc[11:0] : bint;
    wire logic signed [13:0] bl =
      $signed({2'b00, bsel[ch]}) - $signed({6'h00, lift});
    assign braw[ch] = !lift_on ? bsel[ch] :
      bl[13] ? 12'h000 : bl[11:0];
    // Apply the clamped reductions to each band and recombine.
    wire logic [15:0] gm = gq15(mapp[ch]);
    wire logic [15:0] gb = gq15(bapp[ch]);
    wire logic signed [32:0] pm = hi[ch] * $signed({1'b0, gm});
    wire logic signed [32:0] pb = lo[ch] * $signed({1'b0, gb});
    assign yout[ch] = sat16($signed({pm[30], pm[30:15]}) +
      $signed({pb[30], pb[30:15]}));

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        lo_acc <= 32'sh00000000;
        mgr[ch] <= 24'h000000;
        bgr[ch] <= 24'h000000;
      end else if (SAMPLE_EN) begin
        lo_acc <= next_lo;
        mgr[ch] <= approach(mgr[ch], mt, mrate);
        bgr[ch] <= approach(bgr[ch], bt, brate);
      end
    end

    // Window rate checks for this channel.
    a_rate_inside: assert property (@(posedge REF_CLK)
      disable iff (!RESET_N) (!gate && mag4 < 26'(edg)) |->
      mrate == wrel) else $error("inside window rate wrong");
    a_rate_outside: assert property (@(posedge REF_CLK)
      disable iff (!RESET_N) (!gate && mag >= edg) |->
      mrate == fast) else $error("outside window rate wrong");
    a_soft_edge: assert property (@(posedge REF_CLK)
      disable iff (!RESET_N)
      (!gate && mag4 >= e2 && mag < edg && fast >= wrel) |->
      (mrate > wrel || fast == wrel) && mrate <= fast)
      else $error("window blend out of bounds");
  end

  // Output matrix back to left and right.
  wire logic signed [16:0] y_sum = 17'(yout[0]) + 17'(yout[1]);
  wire logic signed [16:0] y_dif = 17'(yout[0]) - 17'(yout[1]);
  wire stereo_s next_out = sd_mode ?
    {sat16(y_sum), sat16(y_dif)} : {yout[0], yout[1]};

  // Setting registers sit at the low indexes.
  wire logic cfg_hit = REG_ADDR < 5'(`NCFG);
  wire logic [15:0] stat_mux =
    (REG_ADDR == `S_MGR0) ? {4'h0, mapp[0]} :
    (REG_ADDR == `S_MGR1) ? {4'h0, mapp[1]} :
    (REG_ADDR == `S_BGR0) ? {4'h0, bapp[0]} :
    (REG_ADDR == `S_BGR1) ? {4'h0, bapp[1]} :
    (REG_ADDR == `S_FLAG) ? {13'h0000, lift_on, mb_gate, gate} :
    16'h0000;
  wire logic [15:0] rd_mux = cfg_hit ? cfg[REG_ADDR] : stat_mux;

  // Setting writes; unmapped writes are dropped.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < `NCFG; i++) begin
        cfg[i] <= rst_val(5'(i));
      end
    end else if (REG_WR && cfg_hit) begin
      cfg[REG_ADDR] <= REG_WDATA;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= 16'h0000;
    end else begin
      REG_RDATA <= REG_RD ? rd_mux : 16'h0000;
    end
  end

  // Output sample, one cycle after its enable.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OUT_DATA <= '0;
      OUT_VALID <= 1'b0;
    end else begin
      OUT_VALID <= SAMPLE_EN;
      if (SAMPLE_EN) begin
        OUT_DATA <= next_out;
      end
    end
  end

  // Checks on the coupling, spread, gate and timing.
  a_bass_floor: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N) $signed({2'b00, bsel[0]}) >=
    $signed({2'b00, mraw[0]}) - $signed({6'h00, cpl}))
    else $error("bass below coupling floor");
  a_no_boost: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N) (cpl == 8'h00 && !lift_on) |->
    bapp[0] >= mapp[0]) else $error("bass boost at zero coupling");
  a_spread_lim: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N) mapp[1] <= 13'(mapp[0]) + 13'(spread) &&
    13'(mapp[1]) + 13'(spread) >= 13'(mapp[0]))
    else $error("channel spread exceeded");
  a_spread_zero: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N) spread == 12'h000 |->
    bapp[1] == bapp[0]) else $error("zero spread not equal");
  a_lift_off: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N) !mbg_en |-> braw[1] == bsel[1])
    else $error("lift applied with gate off");
  a_state_hold: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N) !SAMPLE_EN |=>
    $stable(mgr[0]) && $stable(bgr[1])) else $error("state moved");
  a_out_valid: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N) OUT_VALID == $past(SAMPLE_EN))
    else $error("output valid timing");
  a_win_default: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N) $rose(RESET_N) |-> win == `RV_WIN)
    else $error("window reset value");
  a_gate_move: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N) (gate && SAMPLE_EN &&
    mgr[0] < {idle, 12'h000} && wrel != 16'h0000) |=>
    mgr[0] > $past(mgr[0])) else $error("gate not moving to idle");

  c_sd_mode: cover property (@(posedge REF_CLK) sd_mode && SAMPLE_EN);
  c_gated: cover property (@(posedge REF_CLK) gate ##1 SAMPLE_EN);
  c_clamped: cover property (@(posedge REF_CLK) mapp[1] != mraw[1]);
  c_lift: cover property (@(posedge REF_CLK) braw[0] < bsel[0]);
endmodule
`default_nettype wire

// ---- tb/agc_stream_partner.sv ----
/*
  Stream partner of the AGC: upstream sample source and downstream sink.
  Assumes the AGC sits on the same clock and reset as this model.
*/
`timescale 1ns/1ps
`default_nettype none
module agc_stream_partner
  import agc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control from the bench.
  input wire logic run,
  input wire logic slow,
  input wire stereo_s level,
  // Source side.
  output logic sample_en,
  output stereo_s in_data,
  // Sink side.
  input wire logic out_valid,
  input wire stereo_s out_data,
  output stereo_s last_out,
  output int errs
);
  logic phase; // Toggles each cycle to pace the slow mode.
  logic en_q; // Enable of the previous cycle, for the valid check.
  logic fire; // A sample goes out in the coming cycle.
  // Slow mode sends every other cycle, so gaps in the stream are covered.
  assign fire = run && (!slow || phase);
  // Between samples the data toggles, so a stale word is never mistaken.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      sample_en <= 1'b0;
      in_data <= '0;
      en_q <= 1'b0;
      last_out <= '0;
      errs <= 0;
    end else begin
      phase <= ~phase;
      sample_en <= fire;
      in_data <= fire ? level : ~in_data;
      en_q <= sample_en;
      // Every output word must follow its sample by exactly one cycle.
      if (out_valid !== en_q) begin
        errs <= errs + 1;
      end
      if (out_valid) begin
        last_out <= out_data;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_two_band_audio_agc.sv ----
/*
  Self-checking bench of the two-band AGC.
  Assumes the design package and header are compiled beforehand.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk_val(g, e)
module tb_two_band_audio_agc;
  import agc_pkg::*;
  logic ref_clk = 1'b0; // 10 MHz sample clock.
  logic reset_n = 1'b0; // Held low at start.
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic sample_en;
  stereo_s in_data;
  stereo_s out_data;
  logic out_valid;
  logic run = 1'b0; // Starts and stops the partner stream.
  logic slow = 1'b0; // Sends a sample every other cycle when set.
  stereo_s level = '0; // Word the partner keeps sending.
  stereo_s last_out;
  int errs;
  int failures = 0;
  int checked = 0;
  always #50 ref_clk = ~ref_clk;
  agc_two_band i_dut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .SAMPLE_EN(sample_en), .IN_DATA(in_data),
    .OUT_DATA(out_data), .OUT_VALID(out_valid)
  );
  agc_stream_partner i_partner (
    .clk(ref_clk), .rst_n(reset_n), .run(run), .slow(slow),
    .level(level), .sample_en(sample_en), .in_data(in_data),
    .out_valid(out_valid), .out_data(out_data), .last_out(last_out),
    .errs(errs)
  );
  // Counts one comparison and reports a mismatch at once.
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One write cycle; an edge passes before any next strobe.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // One read cycle; data stand only in the following cycle.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    `CHK({16'h0000, d}, {16'h0000, e});
  endtask
  // Allows for crossover rounding and the gain just below unity.
  function automatic logic near(input logic signed [15:0] a,
                                input logic signed [15:0] b);
    int dd;
    dd = int'(a) - int'(b);
    return (dd > -80) && (dd < 80);
  endfunction
  // Reset values, a read-back, the ratio codes and an unmapped place.
  task automatic t_regs;
    logic [4:0] ra [9] = '{5'h05, 5'h02, 5'h03, 5'h06, 5'h07, 5'h08,
                           5'h0A, 5'h0B, 5'h04};
    logic [15:0] rv [9] = '{16'h0018, 16'hFF80, 16'hFF80, 16'h0200,
                            16'h0040, 16'h0200, 16'h0008, 16'hFE20,
                            16'h0000};
    for (int i = 0; i < 9; i++) begin
      rdchk(ra[i], rv[i]);
    end
    // Read data must fall back to zero one cycle later.
    @(posedge ref_clk);
    #1 `CHK(reg_rdata, 16'h0000);
    for (int r = 0; r < 4; r++) begin
      wr(5'h00, 16'(r << 2));
      rdchk(5'h00, 16'(r << 2));
    end
    wr(5'h04, 16'h0020);
    rdchk(5'h04, 16'h0020);
    wr(5'h04, 16'h0000);
    wr(5'h12, 16'h1234);
    rdchk(5'h12, 16'h0000);
    $display("test registers done");
  endtask
  // Unreduced DC passes through every crossover and matrix mode.
  task automatic t_stream;
    wr(5'h02, 16'h0100);
    wr(5'h03, 16'h0100);
    @(posedge ref_clk);
    level <= 32'h2000_1000;
    for (int m = 0; m < 4; m++) begin
      wr(5'h00, 16'(m));
      @(posedge ref_clk);
      run <= 1'b1;
      repeat (500) @(posedge ref_clk);
      `CHK(near(last_out.left, 16'sh2000), 1'b1);
      `CHK(near(last_out.right, 16'sh1000), 1'b1);
      rdchk(5'h18, 16'h0000);
    end
    run <= 1'b0;
    `CHK(errs, 0);
    $display("test stream done");
  endtask
  // Silence drives the gain to the idle target; lift and matrix on top.
  task automatic t_gate;
    logic [15:0] d;
    wr(5'h0A, 16'h1000);
    wr(5'h01, 16'h0050);
    wr(5'h00, 16'h0010);
    @(posedge ref_clk);
    level <= '0;
    slow <= 1'b1;
    run <= 1'b1;
    repeat (300) @(posedge ref_clk);
    rdchk(5'h18, 16'h0050);
    rdchk(5'h1A, 16'h0050);
    rd(5'h1C, d);
    `CHK(d[0], 1'b1);
    wr(5'h0C, 16'h0010);
    repeat (100) @(posedge ref_clk);
    rdchk(5'h18, 16'h0040);
    wr(5'h00, 16'h0011);
    repeat (60) @(posedge ref_clk);
    rdchk(5'h19, 16'h0040);
    wr(5'h11, 16'h0010);
    repeat (60) @(posedge ref_clk);
    rdchk(5'h1A, 16'h0040);
    rd(5'h1C, d);
    `CHK(d[2], 1'b0);
    wr(5'h00, 16'h0031);
    repeat (60) @(posedge ref_clk);
    rdchk(5'h1A, 16'h0030);
    rdchk(5'h18, 16'h0040);
    rd(5'h1C, d);
    `CHK(d[2], 1'b1);
    `CHK(errs, 0);
    $display("test gate done");
  endtask
  // Full-scale DC settles the bass band exactly at 0 dB, so the bass
  // reduction shows the ratio slope and the coupling-weighted threshold.
  task automatic t_ratio;
    wr(5'h01, 16'h0000);
    wr(5'h03, 16'hFF80);
    wr(5'h08, 16'h4000);
    wr(5'h09, 16'h4000);
    wr(5'h00, 16'h0000);
    @(posedge ref_clk);
    level <= 32'h8000_8000;
    slow <= 1'b0;
    repeat (900) @(posedge ref_clk);
    rdchk(5'h1A, 16'h0080);
    wr(5'h00, 16'h000C);
    repeat (40) @(posedge ref_clk);
    rdchk(5'h1A, 16'h0040);
    rdchk(5'h1B, 16'h0040);
    wr(5'h04, 16'h0080);
    repeat (40) @(posedge ref_clk);
    rdchk(5'h1A, 16'h0020);
    wr(5'h04, 16'h0000);
    $display("test ratio done");
  endtask
  // A reset in mid-run clears gain states and restores settings.
  task automatic t_reset;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    run <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdchk(5'h18, 16'h0000);
    rdchk(5'h1B, 16'h0000);
    rdchk(5'h0A, 16'h0008);
    $display("test reset done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence: reset for five cycles, then each test in turn.
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_stream;
    t_gate;
    t_ratio;
    t_reset;
    test_done;
  end
  // The tests need about 4000 cycles; this margin catches a hang.
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    $display("watchdog expired");
    test_done;
  end
endmodule
`default_nettype wire
